// file: verilog/pin_mux_top.sv
// Register file, PWM routing outputs and Port H pin multiplexer.
`timescale 1ns/1ps
module pin_mux_top
    import pin_mux_pkg::*;
(
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_reset,
    // Avalon-MM slave
    input  wire logic [pin_mux_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                        i_avs_read,
    input  wire logic                        i_avs_write,
    input  wire logic [3:0]                  i_avs_byteenable,
    input  wire logic [pin_mux_pkg::DATA_W-1:0] i_avs_writedata,
    output logic      [pin_mux_pkg::DATA_W-1:0] o_avs_readdata,
    output logic                             o_avs_waitrequest,
    // PWM channel sources
    input  wire logic [7:0]                  i_pwm_en,
    input  wire logic [7:0]                  i_pwm_val,
    // PWM pin ownership and levels
    output logic      [7:0]                  o_pwm_pp_en,
    output logic      [7:0]                  o_pwm_pp_val,
    output logic      [7:0]                  o_pwm_ps_en,
    output logic      [7:0]                  o_pwm_ps_val,
    output logic      [3:0]                  o_pwm_pv_en,
    output logic      [3:0]                  o_pwm_pv_val,
    // LCD segment enables per Port H pin
    input  wire logic [7:0]                  i_lcd_en,
    // Two-wire serial unit
    input  wire logic                        i_two_wire_serial_unit_en,
    input  wire logic                        i_sda_out,
    input  wire logic                        i_sda_oe,
    input  wire logic                        i_scl_out,
    input  wire logic                        i_scl_oe,
    output logic                             o_sda_in,
    output logic                             o_scl_in,
    // SPI routed to Port H
    input  wire logic                        i_spi_en,
    input  wire logic                        i_ss_out,
    input  wire logic                        i_ss_oe,
    input  wire logic                        i_sck_out,
    input  wire logic                        i_sck_oe,
    input  wire logic                        i_mosi_out,
    input  wire logic                        i_mosi_oe,
    input  wire logic                        i_miso_out,
    input  wire logic                        i_miso_oe,
    output logic                             o_ss_in,
    output logic                             o_sck_in,
    output logic                             o_mosi_in,
    output logic                             o_miso_in,
    // Bus clock output
    input  wire logic                        i_bus_clock_output_en,
    input  wire logic                        i_bus_clock_output_val,
    // Port H pins
    input  wire logic [7:0]                  i_ph_in,
    output logic      [7:0]                  o_ph_out,
    output logic      [7:0]                  o_ph_oe,
    output logic      [7:0]                  o_ph_ie,
    output logic      [7:0]                  o_ph_lcd
);

    // ***********************************************************
    // Registers and wires
    // ***********************************************************
    logic [7:0] route_h_q;     // PWM7 routing select
    logic [7:0] route_l_q;     // PWM6..0 routing select
    logic [7:0] port_h_data_latch_q; // Output latch
    logic [7:0] port_h_direction_q;  // Direction bits
    logic [7:0] sync1_q;       // First sync stage
    logic [7:0] in_buf_q;      // Buffered pin state
    logic       wait_q;        // Waitrequest flop
    logic [DATA_W-1:0] rdata_q; // Read data flop
    logic       acc_ack;       // Access completes this edge
    logic       wr_ack;        // Write completes this edge
    logic [7:0] pin_out_d;     // Next pin levels
    logic [7:0] pin_oe_d;      // Next pin enables
    logic [7:0] pin_ie_d;      // Next input enables
    logic [7:0] pp_en_d;       // Router outputs
    logic [7:0] pp_val_d;
    logic [7:0] ps_en_d;
    logic [7:0] ps_val_d;
    logic [3:0] pv_en_d;
    logic [3:0] pv_val_d;

    // Read value of the data register
    function automatic logic [7:0] data_view(
        input logic [7:0] dir,
        input logic [7:0] latch,
        input logic [7:0] pins
    );
        data_view = (dir & latch) | (~dir & pins);
    endfunction

    // Word decode for reads, unmapped reads give zero
    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            ADDR_PWM7_ROUTE: v = route_h_q;
            ADDR_PWM6_ROUTE: v = route_l_q;
            ADDR_PH_DATA:    v = data_view(port_h_direction_q,
                                   port_h_data_latch_q, in_buf_q);
            ADDR_PH_DIR:     v = port_h_direction_q;
            ADDR_PH_INPUT:   v = in_buf_q;
            default:         v = 8'h00;
        endcase
        read_mux = {24'h000000, v};
    endfunction

    // ***********************************************************
    // Avalon-MM slave handshake
    // ***********************************************************
    // One wait cycle per access keeps read data a plain flop
    assign acc_ack = (i_avs_read | i_avs_write) & ~wait_q;
    assign wr_ack  = i_avs_write & ~wait_q & i_avs_byteenable[0];

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wait_q <= 1'b1;
        end else if ((i_avs_read | i_avs_write) & wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read data captured as waitrequest falls, held after
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else if (i_avs_read & wait_q) begin
            rdata_q <= read_mux(i_avs_address);
        end
    end

    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata    = rdata_q;

    // ***********************************************************
    // Software registers
    // ***********************************************************
    // Writes land at the edge where waitrequest is seen low
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            route_h_q           <= RST_PWM7_ROUTE;
            route_l_q           <= RST_PWM6_ROUTE;
            port_h_data_latch_q <= RST_PH_DATA;
            port_h_direction_q  <= RST_PH_DIR;
        end else if (wr_ack) begin
            unique case (i_avs_address)
                ADDR_PWM7_ROUTE: route_h_q <= i_avs_writedata[7:0];
                ADDR_PWM6_ROUTE: route_l_q <= i_avs_writedata[7:0];
                // No access restriction on the latch
                ADDR_PH_DATA: begin
                    port_h_data_latch_q <= i_avs_writedata[7:0];
                end
                ADDR_PH_DIR: port_h_direction_q <= i_avs_writedata[7:0];
                default: ; // Unmapped and read-only words ignore writes
            endcase
        end
    end

    // ***********************************************************
    // Pin input synchroniser
    // ***********************************************************
    // Two stages, so reads trail the pins by two cycles
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_q  <= 8'h00;
            in_buf_q <= 8'h00;
        end else begin
            sync1_q  <= i_ph_in;
            in_buf_q <= sync1_q;
        end
    end

    // Peripheral receive paths read the buffered state
    assign o_sda_in  = in_buf_q[PH_PIN3];
    assign o_ss_in   = in_buf_q[PH_PIN3];
    assign o_sck_in  = in_buf_q[PH_PIN2];
    assign o_mosi_in = in_buf_q[PH_PIN1];
    assign o_scl_in  = in_buf_q[PH_PIN0];
    assign o_miso_in = in_buf_q[PH_PIN0];

    // ***********************************************************
    // PWM routing
    // ***********************************************************
    pwm_route u_route (
        .i_route_h (route_h_q[1:0]),
        .i_route_l (route_l_q),
        .i_pwm_en  (i_pwm_en),
        .i_pwm_val (i_pwm_val),
        .o_pp_en   (pp_en_d),
        .o_pp_val  (pp_val_d),
        .o_ps_en   (ps_en_d),
        .o_ps_val  (ps_val_d),
        .o_pv_en   (pv_en_d),
        .o_pv_val  (pv_val_d)
    );

    // Registered so every pin output comes from a flop
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pwm_pp_en  <= 8'h00;
            o_pwm_pp_val <= 8'h00;
            o_pwm_ps_en  <= 8'h00;
            o_pwm_ps_val <= 8'h00;
            o_pwm_pv_en  <= 4'h0;
            o_pwm_pv_val <= 4'h0;
        end else begin
            o_pwm_pp_en  <= pp_en_d;
            o_pwm_pp_val <= pp_val_d;
            o_pwm_ps_en  <= ps_en_d;
            o_pwm_ps_val <= ps_val_d;
            o_pwm_pv_en  <= pv_en_d;
            o_pwm_pv_val <= pv_val_d;
        end
    end

    // ***********************************************************
    // Port H priority multiplexer
    // ***********************************************************
    // Lowest priority first, later assignments win
    always_comb begin
        pin_out_d = port_h_data_latch_q;
        pin_oe_d  = port_h_direction_q;
        pin_ie_d  = 8'hff;
        // Pin 3: I2C data above SPI select
        if (i_two_wire_serial_unit_en) begin
            pin_out_d[PH_PIN3] = i_sda_out;
            pin_oe_d[PH_PIN3]  = i_sda_oe;
        end else if (i_spi_en) begin
            pin_out_d[PH_PIN3] = i_ss_out;
            pin_oe_d[PH_PIN3]  = i_ss_oe;
        end
        // Pin 2: SPI clock above bus clock output
        if (i_spi_en) begin
            pin_out_d[PH_PIN2] = i_sck_out;
            pin_oe_d[PH_PIN2]  = i_sck_oe;
        end else if (i_bus_clock_output_en) begin
            pin_out_d[PH_PIN2] = i_bus_clock_output_val;
            pin_oe_d[PH_PIN2]  = 1'b1;
        end
        // Pin 1: SPI MOSI only
        if (i_spi_en) begin
            pin_out_d[PH_PIN1] = i_mosi_out;
            pin_oe_d[PH_PIN1]  = i_mosi_oe;
        end
        // Pin 0: I2C clock above SPI MISO
        if (i_two_wire_serial_unit_en) begin
            pin_out_d[PH_PIN0] = i_scl_out;
            pin_oe_d[PH_PIN0]  = i_scl_oe;
        end else if (i_spi_en) begin
            pin_out_d[PH_PIN0] = i_miso_out;
            pin_oe_d[PH_PIN0]  = i_miso_oe;
        end
        // LCD segment wins on every pin and isolates it
        for (int k = 0; k < 8; k++) begin
            if (i_lcd_en[k]) begin
                pin_out_d[k] = 1'b0;
                pin_oe_d[k]  = 1'b0;
                pin_ie_d[k]  = 1'b0;
            end
        end
    end

    // Pin drivers, one cycle behind their sources
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_ph_out <= 8'h00;
            o_ph_oe  <= 8'h00;
            o_ph_ie  <= 8'h00;
            o_ph_lcd <= 8'h00;
        end else begin
            o_ph_out <= pin_out_d;
            o_ph_oe  <= pin_oe_d;
            o_ph_ie  <= pin_ie_d;
            o_ph_lcd <= i_lcd_en;
        end
    end

    // ***********************************************************
    // Assertions
    // ***********************************************************
    a_pwm7_port_s: assert property (@(posedge i_clk) disable iff (i_reset)
        o_pwm_ps_en[1] == ($past(i_pwm_en[7]) &&
                           $past(route_h_q[1:0]) == RT_PORT_S))
        else $error("PWM7 port S ownership wrong");

    a_pwm7_code3_p: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(route_h_q[1:0]) == RT_PORT_P2 && $past(i_pwm_en[7]))
        |-> o_pwm_pp_en[7] && !o_pwm_pv_en[3])
        else $error("PWM7 code 3 not on port P");

    a_pwm6_port_v: assert property (@(posedge i_clk) disable iff (i_reset)
        o_pwm_pv_en[2] == ($past(i_pwm_en[6]) &&
                           $past(route_l_q[7:6]) == RT_PORT_V))
        else $error("PWM6 port V ownership wrong");

    // Flops still held in reset one edge back, so skip that first edge
    a_pwm5_port_p: assert property (@(posedge i_clk) disable iff (i_reset)
        !$past(i_reset) |->
        o_pwm_pp_en[5] == ($past(i_pwm_en[5]) && !$past(route_l_q[5])))
        else $error("PWM5 port P ownership wrong");

    a_pwm0_port_s: assert property (@(posedge i_clk) disable iff (i_reset)
        $past(route_l_q[0]) |->
        o_pwm_ps_en[4] == $past(i_pwm_en[0]) && !o_pwm_pp_en[0])
        else $error("PWM0 not on port S pin 4");

    a_data_read_mix: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(i_avs_read) && $past(wait_q) &&
         $past(i_avs_address) == ADDR_PH_DATA) |->
        o_avs_readdata[7:0] == (($past(port_h_direction_q) &
            $past(port_h_data_latch_q)) | (~$past(port_h_direction_q) &
            $past(in_buf_q))))
        else $error("Data read mixes latch and pins wrongly");

    a_data_write: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr_ack && i_avs_address == ADDR_PH_DATA) |=>
        port_h_data_latch_q == $past(i_avs_writedata[7:0]))
        else $error("Data write not stored");

    a_bus_one_wait: assert property (@(posedge i_clk) disable iff (i_reset)
        ((i_avs_read || i_avs_write) && wait_q) |=> !wait_q ##1 wait_q)
        else $error("Access not answered after one cycle");

    a_lcd_isolate: assert property (@(posedge i_clk) disable iff (i_reset)
        $past(i_lcd_en[7]) |-> !o_ph_oe[7] && !o_ph_ie[7])
        else $error("LCD pin not isolated");

    a_pin3_i2c_first: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(!i_lcd_en[3]) && $past(i_two_wire_serial_unit_en)) |->
        o_ph_oe[3] == $past(i_sda_oe))
        else $error("Pin 3 not owned by I2C data");

    a_pin2_busclk: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(!i_lcd_en[2] && !i_spi_en && i_bus_clock_output_en)) |->
        o_ph_oe[2] && o_ph_out[2] == $past(i_bus_clock_output_val))
        else $error("Pin 2 bus clock output wrong");

    a_pin1_mosi: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(!i_lcd_en[1] && i_spi_en)) |->
        o_ph_out[1] == $past(i_mosi_out))
        else $error("Pin 1 not owned by MOSI");

    a_pin0_scl: assert property (@(posedge i_clk) disable iff (i_reset)
        ($past(!i_lcd_en[0] && i_two_wire_serial_unit_en)) |->
        o_ph_oe[0] == $past(i_scl_oe))
        else $error("Pin 0 not owned by I2C clock");

    a_gpio_dir: assert property (@(posedge i_clk) disable iff (i_reset)
        $past(!i_lcd_en[6]) |-> o_ph_oe[6] == $past(port_h_direction_q[6]))
        else $error("GPIO direction not applied");

    a_sync_two: assert property (@(posedge i_clk) disable iff (i_reset)
        $past(!i_reset, 2) |-> in_buf_q == $past(i_ph_in, 2))
        else $error("Input sync delay not two cycles");

endmodule

// file: verilog/pin_mux_pkg.sv
// Constants for the PWM routing and Port H pin multiplexer.
// Function
// - PWM7 pin from high routing bits 1:0
// - PWM6 pin from low routing bits 7:6
// - PWM5/4 to P5/P4 or V1/V0
// - PWM3..0 to P3..0 or S7..4
// - Data read: latch if output, else pin
// - Data register read and write anytime
// - LCD overrides GPIO on pins 7..4
// - Pin3: LCD, I2C data, SPI select, GPIO
// - Pin2: LCD, SPI clock, bus clock, GPIO
// - Pin1: LCD, SPI MOSI, GPIO
// - Pin0: LCD, I2C clock, SPI MISO, GPIO
// - Direction 1 output, 0 input otherwise
// - LCD disables pin input and output
// - Pin input synchronised, two cycles late
package pin_mux_pkg;

    // ***********************************************************
    // Bus and register geometry
    // ***********************************************************
    localparam int unsigned ADDR_W = 5;  // Byte address width
    localparam int unsigned DATA_W = 32; // Avalon data width
    localparam int unsigned REG_W  = 8;  // Register width

    // Byte offsets of the register words
    localparam logic [4:0] ADDR_PWM7_ROUTE  = 5'h00;
    localparam logic [4:0] ADDR_PWM6_ROUTE  = 5'h04;
    localparam logic [4:0] ADDR_PH_DATA     = 5'h08;
    localparam logic [4:0] ADDR_PH_DIR      = 5'h0c;
    localparam logic [4:0] ADDR_PH_INPUT    = 5'h10;

    // Reset values, all cleared
    localparam logic [7:0] RST_PWM7_ROUTE = 8'h00;
    localparam logic [7:0] RST_PWM6_ROUTE = 8'h00;
    localparam logic [7:0] RST_PH_DATA    = 8'h00;
    localparam logic [7:0] RST_PH_DIR     = 8'h00;

    // ***********************************************************
    // Routing field codes
    // ***********************************************************
    localparam logic [1:0] RT_PORT_P  = 2'h0; // Also code 3
    localparam logic [1:0] RT_PORT_S  = 2'h1;
    localparam logic [1:0] RT_PORT_V  = 2'h2;
    localparam logic [1:0] RT_PORT_P2 = 2'h3;

    // Field positions in the low routing register
    localparam int unsigned F_PWM6_HI = 7;
    localparam int unsigned F_PWM6_LO = 6;
    localparam int unsigned F_PWM5    = 5;
    localparam int unsigned F_PWM4    = 4;

    // ***********************************************************
    // Port H pin positions and timing
    // ***********************************************************
    localparam int unsigned PH_PIN0   = 0;
    localparam int unsigned PH_PIN1   = 1;
    localparam int unsigned PH_PIN2   = 2;
    localparam int unsigned PH_PIN3   = 3;
    localparam int unsigned SYNC_CYC  = 2; // Input sync depth

endpackage

// file: verilog/pwm_route.sv
// Combinational steering of eight PWM channels onto port pins.
`timescale 1ns/1ps
module pwm_route
    import pin_mux_pkg::*;
(
    // Routing selections
    input  wire logic [1:0] i_route_h,
    input  wire logic [7:0] i_route_l,
    // PWM channel sources
    input  wire logic [7:0] i_pwm_en,
    input  wire logic [7:0] i_pwm_val,
    // Port P destination
    output logic      [7:0] o_pp_en,
    output logic      [7:0] o_pp_val,
    // Port S destination
    output logic      [7:0] o_ps_en,
    output logic      [7:0] o_ps_val,
    // Port V destination
    output logic      [3:0] o_pv_en,
    output logic      [3:0] o_pv_val
);

    // Unselected pins stay clear so their own functions keep them
    always_comb begin
        o_pp_en  = 8'h00;
        o_pp_val = 8'h00;
        o_ps_en  = 8'h00;
        o_ps_val = 8'h00;
        o_pv_en  = 4'h0;
        o_pv_val = 4'h0;
        // Channel 7, codes 0 and 3 both mean port P
        unique case (i_route_h)
            RT_PORT_S: begin
                o_ps_en[1]  = i_pwm_en[7];
                o_ps_val[1] = i_pwm_val[7];
            end
            RT_PORT_V: begin
                o_pv_en[3]  = i_pwm_en[7];
                o_pv_val[3] = i_pwm_val[7];
            end
            default: begin
                o_pp_en[7]  = i_pwm_en[7];
                o_pp_val[7] = i_pwm_val[7];
            end
        endcase
        // Channel 6 from the top field of the low register
        unique case (i_route_l[F_PWM6_HI:F_PWM6_LO])
            RT_PORT_S: begin
                o_ps_en[0]  = i_pwm_en[6];
                o_ps_val[0] = i_pwm_val[6];
            end
            RT_PORT_V: begin
                o_pv_en[2]  = i_pwm_en[6];
                o_pv_val[2] = i_pwm_val[6];
            end
            default: begin
                o_pp_en[6]  = i_pwm_en[6];
                o_pp_val[6] = i_pwm_val[6];
            end
        endcase
        // Channels 5 and 4 go to port V pins 1 and 0
        for (int k = 4; k < 6; k++) begin
            if (i_route_l[k]) begin
                o_pv_en[k-4]  = i_pwm_en[k];
                o_pv_val[k-4] = i_pwm_val[k];
            end else begin
                o_pp_en[k]  = i_pwm_en[k];
                o_pp_val[k] = i_pwm_val[k];
            end
        end
        // Channels 3..0 go to port S pins 7..4
        for (int k = 0; k < 4; k++) begin
            if (i_route_l[k]) begin
                o_ps_en[k+4]  = i_pwm_en[k];
                o_ps_val[k+4] = i_pwm_val[k];
            end else begin
                o_pp_en[k]  = i_pwm_en[k];
                o_pp_val[k] = i_pwm_val[k];
            end
        end
    end

endmodule

// file: dv/ph_pin_model.sv
// Behavioural model of the Port H package pins and their far side.
`timescale 1ns/1ps
module ph_pin_model (
    // Drive from the multiplexer
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    // Level the outside world puts on undriven pins
    input  wire logic [7:0] i_ext,
    // Resolved pin levels
    output logic      [7:0] o_pin
);
    // Driven pins show the mux level, others the outside level
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule

// file: dv/tb_top.sv
// Register and pin level testbench for the Port H and PWM multiplexer.
`timescale 1ns/1ps
module tb_top;
    import pin_mux_pkg::*;
    `define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
        num_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
    logic i_clk = 0, i_reset = 1, rd = 0, wr = 0;
    logic [4:0] addr = 0;
    logic [31:0] wd = 0, rdata;
    logic wt, i2c = 0, spi = 0, ec = 0, pol = 0;
    logic [7:0] lcd = 0, ext = 8'h00, pins, q, pp, ps, oe, out, ie, lc;
    logic [3:0] pv, pvv;
    logic [7:0] pen = 8'hff, ppv, psv;
    wire  [5:0] rx;
    int num_errors = 0, checks_done = 0;
    // ***************************************************
    // Design, pins and clock
    // ***************************************************
    pin_mux_top DUT (.i_clk(i_clk), .i_reset(i_reset),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_byteenable(4'h1), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wt),
        .i_pwm_en(pen), .i_pwm_val(8'ha5), .o_pwm_pp_en(pp),
        .o_pwm_pp_val(ppv), .o_pwm_ps_en(ps), .o_pwm_ps_val(psv),
        .o_pwm_pv_en(pv), .o_pwm_pv_val(pvv), .i_lcd_en(lcd),
        .i_two_wire_serial_unit_en(i2c), .i_sda_out(~pol),
        .i_sda_oe(1'b1), .i_scl_out(~pol), .i_scl_oe(1'b1),
        .o_sda_in(rx[5]), .o_scl_in(rx[1]), .i_spi_en(spi),
        .i_ss_out(pol),
        .i_ss_oe(~pol), .i_sck_out(pol), .i_sck_oe(~pol),
        .i_mosi_out(pol), .i_mosi_oe(~pol), .i_miso_out(pol),
        .i_miso_oe(~pol), .o_ss_in(rx[4]), .o_sck_in(rx[3]),
        .o_mosi_in(rx[2]), .o_miso_in(rx[0]), .i_bus_clock_output_en(ec),
        .i_bus_clock_output_val(~pol), .i_ph_in(pins), .o_ph_out(out),
        .o_ph_oe(oe), .o_ph_ie(ie), .o_ph_lcd(lc));
    ph_pin_model PINS (.i_out(out), .i_oe(oe), .i_ext(ext), .o_pin(pins));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // Verdict; also the exit of every timed out wait
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One Avalon access; held until waitrequest is seen low
    task automatic bus(input logic [4:0] a, input logic w,
                       input logic [7:0] d);
        int n;
        @(posedge i_clk);
        addr <= a; rd <= ~w; wr <= w; wd <= {24'h0, d};
        n = 0;
        do begin @(posedge i_clk); n++; end while (wt !== 1'b0 && n < 50);
        if (n >= 50) begin num_errors++; end_sim(); end
        q = rdata[7:0];
        rd <= 1'b0; wr <= 1'b0;
    endtask
    // Expected pin drive from owners; direction is kept at 0 here
    task automatic pin_exp(output logic [7:0] e_oe, e_out);
        e_oe = 0; e_out = 0;
        if (!lcd[3] && i2c) {e_oe[3], e_out[3]} = {1'b1, ~pol};
        else if (!lcd[3] && spi) {e_oe[3], e_out[3]} = {~pol, pol};
        if (!lcd[2] && spi) {e_oe[2], e_out[2]} = {~pol, pol};
        else if (!lcd[2] && ec) {e_oe[2], e_out[2]} = {1'b1, ~pol};
        if (!lcd[1] && spi) {e_oe[1], e_out[1]} = {~pol, pol};
        if (!lcd[0] && i2c) {e_oe[0], e_out[0]} = {1'b1, ~pol};
        else if (!lcd[0] && spi) {e_oe[0], e_out[0]} = {~pol, pol};
    endtask
    // ***************************************************
    // Test sequence
    // ***************************************************
    initial begin
        logic [7:0] h, l, eo, ev, rp, rs;
        logic [3:0] rv;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        // Cleared registers; unmapped word reads zero
        for (int a = 0; a <= 5'h14; a += 4) begin
            bus(a[4:0], 1'b0, 8'h00);
            `CHK("reset read", 8'h00, q)
        end
        $display("test reset done");
        // Every routing code on every channel field
        // Upper half also disables some channels and sets spare bits
        for (int k = 0; k < 8; k++) begin
            h = k; l = {h[1:0], 6'h2a ^ {6{h[0]}}};
            pen <= k[2] ? 8'h5a : 8'hff;
            bus(ADDR_PWM7_ROUTE, 1'b1, h);
            bus(ADDR_PWM6_ROUTE, 1'b1, l);
            repeat (2) @(posedge i_clk);
            // Pins that each routing code selects
            rp = {h[1:0] == 0 || h[1:0] == 3, l[7] == l[6],
                ~l[5:4], ~l[3:0]};
            rs = {l[3:0], 2'b0, h[1:0] == 1, l[7:6] == 1};
            rv = {h[1:0] == 2, l[7:6] == 2, l[5:4]};
            `CHK("pp_en", rp & pen, pp)
            `CHK("pp_val", rp & 8'ha5, ppv)
            `CHK("ps_en", rs & {pen[3:0], 2'b0, pen[7:6]}, ps)
            `CHK("ps_val", rs & 8'h52, psv)
            `CHK("pv_en", rv & pen[7:4], pv)
            `CHK("pv_val", rv & 4'ha, pvv)
        end
        $display("test routing done");
        // Mixed directions, pins partly driven from outside
        ext <= 8'h3c;
        bus(ADDR_PH_DIR, 1'b1, 8'h0f);
        bus(ADDR_PH_DATA, 1'b1, 8'h5a);
        bus(ADDR_PH_INPUT, 1'b1, 8'hff);
        bus(5'h14, 1'b1, 8'hff);
        repeat (3) @(posedge i_clk);
        `CHK("gpio oe", 8'h0f, oe)
        `CHK("gpio out", 8'h0a, out & 8'h0f)
        bus(ADDR_PH_DATA, 1'b0, 8'h00);
        `CHK("data read", 8'h3a, q)
        bus(ADDR_PH_INPUT, 1'b0, 8'h00);
        `CHK("input read", 8'h3a, q)
        `CHK("pin rx", 6'h34, rx)
        bus(5'h14, 1'b0, 8'h00);
        `CHK("unmapped", 8'h00, q)
        $display("test gpio done");
        // Every owner mix on every pin, both drive polarities
        bus(ADDR_PH_DIR, 1'b1, 8'h00);
        bus(ADDR_PH_DATA, 1'b1, 8'h00);
        for (int k = 0; k < 32; k++) begin
            @(posedge i_clk);
            lcd <= k[3] ? 8'h99 : 8'h66; i2c <= k[0]; spi <= k[1];
            ec <= k[2]; pol <= k[4];
            repeat (3) @(posedge i_clk);
            pin_exp(eo, ev);
            `CHK("pin oe", eo, oe)
            `CHK("pin out", ev, out)
            `CHK("pin ie", ~lcd, ie)
            `CHK("pin lcd", lcd, lc)
        end
        $display("test priority done");
        end_sim();
    end
endmodule
